// ---- src/acd_pkg.sv ----
// Purpose: constants for the comparator pair control block
// Assumes: 50 MHz clock, word-indexed Avalon-MM slave
// Notes:   register index = printed offset, byte address = 4 * index
package acd_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IX_CTRLA  = 5'h00;
  localparam logic [4:0] IX_CTRLB  = 5'h01;
  localparam logic [4:0] IX_EVCTRL = 5'h02;
  localparam logic [4:0] IX_IENCLR = 5'h04;
  localparam logic [4:0] IX_IENSET = 5'h05;
  localparam logic [4:0] IX_IFLAG  = 5'h06;
  localparam logic [4:0] IX_STATA  = 5'h08;
  localparam logic [4:0] IX_STATB  = 5'h09;
  localparam logic [4:0] IX_STATC  = 5'h0A;
  localparam logic [4:0] IX_WINCTL = 5'h0C;
  localparam logic [4:0] IX_CCTL0  = 5'h10;
  localparam logic [4:0] IX_CCTL1  = 5'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_SOFT_RESET_BIT  = 0;
  localparam int B_ENABLE = 1;
  localparam int B_RUN    = 2;
  localparam int B_WIN    = 4;
  localparam int B_EI0    = 8;
  localparam int B_BUSY   = 7;
  localparam int B_WSTATE = 4;
  localparam int C_EN     = 0;
  localparam int C_SINGLE = 1;
  localparam int C_COMP_IRQ_CONDITION_SELECT = 5;
  localparam int C_SWAP   = 15;
  localparam int C_OUT    = 16;
  localparam int C_FILTER_LENGTH_SELECT   = 24;
  localparam logic [31:0] CCTL_MASK = 32'h070B_F7EF;
  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] OUT_RAW  = 2'h1;
  localparam logic [1:0] OUT_SYNC = 2'h2;
  localparam logic [1:0] IS_TOG   = 2'h0;
  localparam logic [1:0] IS_RISE  = 2'h1;
  localparam logic [1:0] IS_FALL  = 2'h2;
  localparam logic [1:0] WS_ABOVE = 2'h0;
  localparam logic [1:0] WS_IN    = 2'h1;
  localparam logic [1:0] WS_BELOW = 2'h2;
  localparam logic [2:0] FL_N3    = 3'h1;
  localparam logic [2:0] FL_N5    = 3'h2;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 50;
  localparam int STARTUP_NS  = 1000;
  localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC    = 3;
  localparam int SAMPLE_DIV  = 4;
endpackage : acd_pkg

// ---- src/acd_ctrl.sv ----
// Purpose: digital control of a two-comparator pair with window unit
// Assumes: comparator results arrive asynchronously; events on clock
// Notes:   raw pin route is combinational by nature
//
// Local design decisions: the Avalon-MM register port and the register offsets.

// Notes on behaviour
// - output pin shows raw or synchronised filtered result per route field
// - swap bit exchanges inputs and inverts result
// - three flags: comparator 0, comparator 1, window
// - condition select fields choose when each flag is raised
// - ones in enable-set set enables, ones in enable-clear clear them
// - irq high while any flag and its enable are both set
// - writing one to a flag bit clears that flag
// - output events only when their event output enable is one
// - input events act only when event input enable is one
// - event starts compare after start-up; window mode starts both
// - run bit zero: pair powered down in standby, start-up on return
// - run bit one: enabled interrupt sources wake the processor
// - run bit one: event single shots accepted only while idle
// - sleep: continuous stays on, single shot on only when triggered
// - sleep continuous: edges set flags, send events, wake if enabled
// - no filtering for continuous comparisons during sleep
// - sleep single shot: power, start-up, filtered compare, then off
// - synchronised write sets busy at once, clears when applied
// - synchronised write while busy stalls bus, then completes
// - soft reset, enable, comparator enables, window control are synced
// - filter accepts change on majority of last three or five samples
// - start bit acts only on enabled single-shot comparator, reads zero
module acd_ctrl #(
  parameter int STARTUP = acd_pkg::STARTUP_CYC,
  parameter int SYNCD   = acd_pkg::SYNC_CYC,
  parameter int SDIV    = acd_pkg::SAMPLE_DIV
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  comp_result,
  input  wire logic [1:0]  event_in,
  input  wire logic        standby,
  input  wire logic        cpu_idle,
  output logic      [1:0]  comparator_output_pin,
  output logic      [1:0]  comp_power_en,
  output logic      [1:0]  comp_swap,
  output logic      [1:0]  comp_event_out,
  output logic             window_event_out,
  output logic             irq,
  output logic             wake_request
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic maj(input logic [4:0] h, input logic [2:0] f);
    logic [2:0] s3;
    logic [2:0] s5;
    s3 = {2'b00, h[0]} + {2'b00, h[1]} + {2'b00, h[2]};
    s5 = s3 + {2'b00, h[3]} + {2'b00, h[4]};
    if (f == acd_pkg::FL_N3)
      maj = s3 >= 3'd2;
    else if (f == acd_pkg::FL_N5)
      maj = s5 >= 3'd3;
    else
      maj = h[0];
  endfunction : maj

  function automatic logic cond(input logic [1:0] sel, input logic o,
                                input logic n, input logic eoc);
    case (sel)
      acd_pkg::IS_TOG:  cond = o != n;
      acd_pkg::IS_RISE: cond = !o && n;
      acd_pkg::IS_FALL: cond = o && !n;
      default:          cond = eoc;
    endcase
  endfunction : cond

  function automatic logic [1:0] wst(input logic [1:0] s);
    if (s[0] ^ s[1])
      wst = acd_pkg::WS_IN;
    else if (s[0])
      wst = acd_pkg::WS_ABOVE;
    else
      wst = acd_pkg::WS_BELOW;
  endfunction : wst

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0]  ctrla_q;
  logic [1:0]  eo_q;
  logic        weo_q;
  logic [1:0]  ei_q;
  logic [2:0]  ien_q;
  logic [2:0]  flag_q;
  logic [2:0]  winctl_q;
  logic [31:0] cctl_q [2];
  logic        en_eff_q;
  logic [1:0]  cen_eff_q;
  logic [2:0]  win_eff_q;
  logic [31:0] pend_q;
  logic [4:0]  pidx_q;
  logic [7:0]  sync_cnt_q;
  logic        busy_q;
  logic        rd_done_q;
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire is_cctl  = avs_address == acd_pkg::IX_CCTL0 ||
                  avs_address == acd_pkg::IX_CCTL1;
  wire cix      = avs_address == acd_pkg::IX_CCTL1;
  wire sync_hit = avs_address == acd_pkg::IX_CTRLA ||
                  avs_address == acd_pkg::IX_WINCTL || is_cctl;
  wire stall    = avs_write && sync_hit && busy_q;
  wire wr       = avs_write && !stall;
  wire sync_wr  = wr && sync_hit;
  wire do_soft_reset_bit = busy_q && sync_cnt_q == 8'd1 &&
                  pidx_q == acd_pkg::IX_CTRLA && pend_q[acd_pkg::B_SOFT_RESET_BIT];
  wire wr_soft_reset_bit = wr && avs_address == acd_pkg::IX_CTRLA &&
                  avs_writedata[acd_pkg::B_SOFT_RESET_BIT];

  assign avs_waitrequest = (avs_read && !rd_done_q) || stall;

  // ----------------------------------------------------------------
  // comparator datapath
  // ----------------------------------------------------------------
  logic [2:0]  sy_q [2];
  logic [1:0]  stb_q;
  logic [4:0]  hist_q [2];
  logic [1:0]  state_q;
  logic [1:0]  ss_q;
  logic [2:0]  nsmp_q [2];
  logic [15:0] su_q [2];
  logic [7:0]  div_q;
  logic        was_off_q;

  wire tick    = div_q == 8'd0;
  wire asleep  = standby;
  wire off_all = asleep && !ctrla_q[acd_pkg::B_RUN];
  wire sleep_c = asleep && ctrla_q[acd_pkg::B_RUN];
  wire ev_ok   = !ctrla_q[acd_pkg::B_RUN] || cpu_idle;
  wire [1:0] ev_act = event_in & ei_q & {2{ev_ok}};

  logic [1:0] single;
  logic [1:0] val;
  logic [1:0] filt;
  logic [1:0] start;
  logic [1:0] done;
  logic [1:0] newst;
  logic [1:0] ccond;
  logic [2:0] filter_length_select [2];
  logic [1:0] ready;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      single[i] = cctl_q[i][acd_pkg::C_SINGLE];
      filter_length_select[i]   = sleep_c && !single[i] ? 3'h0
                  : cctl_q[i][acd_pkg::C_FILTER_LENGTH_SELECT +: 3];
      val[i]    = stb_q[i] ^ cctl_q[i][acd_pkg::C_SWAP];
      comp_swap[i] = cctl_q[i][acd_pkg::C_SWAP];
      filt[i]   = maj({hist_q[i][3:0], val[i]}, filter_length_select[i]);
      comp_power_en[i] = en_eff_q && cen_eff_q[i] && !off_all &&
                         (!single[i] || ss_q[i]);
      ready[i]  = comp_power_en[i] && su_q[i] == 16'd0;
    end
    // start bit or event; window mode starts both
    start = ev_act;
    if (wr && avs_address == acd_pkg::IX_CTRLB)
      start = start | avs_writedata[1:0];
    if (win_eff_q[0] && start != 2'b00)
      start = 2'b11;
    for (int i = 0; i < 2; i++)
    begin
      start[i] = start[i] && en_eff_q && cen_eff_q[i] &&
                 single[i] && !ss_q[i];
      done[i]  = ss_q[i] && ready[i] && tick &&
                 nsmp_q[i] + 3'd1 >= (filter_length_select[i] == acd_pkg::FL_N5 ? 3'd5 :
                 filter_length_select[i] == acd_pkg::FL_N3 ? 3'd3 : 3'd1);
      newst[i] = state_q[i];
      if (done[i] || (!single[i] && ready[i] && tick))
        newst[i] = filt[i];
      ccond[i] = cond(cctl_q[i][acd_pkg::C_COMP_IRQ_CONDITION_SELECT +: 2], state_q[i],
                      newst[i], done[i]);
    end
  end

  wire [1:0] ws_o   = wst(state_q);
  wire [1:0] ws_n   = wst(newst);
  wire [1:0] wsel   = win_eff_q[2:1];
  wire       wchg   = ws_o != ws_n;
  wire       wcond  = win_eff_q[0] && wchg &&
                      (wsel == 2'h3 ? (ws_o == acd_pkg::WS_IN ||
                       ws_n == acd_pkg::WS_IN) :
                       ws_n == wsel);
  wire [2:0] setv   = {wcond, ccond};

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      case (cctl_q[i][acd_pkg::C_OUT +: 2])
        acd_pkg::OUT_RAW:
          comparator_output_pin[i] =
            comp_result[i] ^ cctl_q[i][acd_pkg::C_SWAP];
        acd_pkg::OUT_SYNC:
          comparator_output_pin[i] = state_q[i];
        default:
          comparator_output_pin[i] = 1'b0;
      endcase
    end
  end

  assign irq          = |(flag_q & ien_q);
  assign wake_request = irq && sleep_c;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // sampling, filter history, single-shot sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_q     <= 8'd0;
      stb_q     <= 2'b00;
      state_q   <= 2'b00;
      ss_q      <= 2'b00;
      was_off_q <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        sy_q[i]   <= 3'd0;
        hist_q[i] <= 5'd0;
        nsmp_q[i] <= 3'd0;
        su_q[i]   <= 16'd0;
      end
    end
    else
    begin
      div_q     <= div_q == 8'(SDIV - 1) ? 8'd0 : div_q + 8'd1;
      was_off_q <= off_all;
      for (int i = 0; i < 2; i++)
      begin
        sy_q[i] <= {sy_q[i][1:0], comp_result[i]};
        if (sy_q[i][1] == sy_q[i][2])
          stb_q[i] <= sy_q[i][2];
        if (!comp_power_en[i] || (was_off_q && !off_all))
          su_q[i] <= 16'(STARTUP);
        else if (su_q[i] != 16'd0)
          su_q[i] <= su_q[i] - 16'd1;
        if (ready[i] && tick)
          hist_q[i] <= {hist_q[i][3:0], val[i]};
        if (start[i])
        begin
          ss_q[i]   <= 1'b1;
          nsmp_q[i] <= 3'd0;
        end
        else if (done[i] || !comp_power_en[i] && !start[i] && ss_q[i]
                 && !(en_eff_q && cen_eff_q[i]))
          ss_q[i] <= 1'b0;
        else if (ss_q[i] && ready[i] && tick)
          nsmp_q[i] <= nsmp_q[i] + 3'd1;
        state_q[i] <= newst[i];
      end
      if (do_soft_reset_bit)
        state_q <= 2'b00;
    end
  end

  // ----------------------------------------------------------------
  // events, flags and enables
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      comp_event_out   <= 2'b00;
      window_event_out <= 1'b0;
      flag_q           <= 3'b000;
      ien_q            <= 3'b000;
    end
    else
    begin
      comp_event_out   <= ccond & eo_q;
      window_event_out <= win_eff_q[0] && wchg && weo_q;
      if (do_soft_reset_bit)
      begin
        flag_q <= 3'b000;
        ien_q  <= 3'b000;
      end
      else
      begin
        // set wins over clear
        if (wr && avs_address == acd_pkg::IX_IFLAG)
          flag_q <= (flag_q & ~{avs_writedata[acd_pkg::B_WIN],
                                avs_writedata[1:0]}) | setv;
        else
          flag_q <= flag_q | setv;
        if (wr && avs_address == acd_pkg::IX_IENSET)
          ien_q <= ien_q | {avs_writedata[acd_pkg::B_WIN],
                   avs_writedata[1:0]};
        if (wr && avs_address == acd_pkg::IX_IENCLR)
          ien_q <= ien_q & ~{avs_writedata[acd_pkg::B_WIN],
                   avs_writedata[1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes and synchronisation
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrla_q    <= 3'b000;
      eo_q       <= 2'b00;
      weo_q      <= 1'b0;
      ei_q       <= 2'b00;
      winctl_q   <= 3'b000;
      en_eff_q   <= 1'b0;
      cen_eff_q  <= 2'b00;
      win_eff_q  <= 3'b000;
      pend_q     <= acd_pkg::RST_VAL;
      pidx_q     <= 5'd0;
      sync_cnt_q <= 8'd0;
      busy_q     <= 1'b0;
      cctl_q[0]  <= acd_pkg::RST_VAL;
      cctl_q[1]  <= acd_pkg::RST_VAL;
    end
    else if (do_soft_reset_bit)
    begin
      ctrla_q    <= 3'b000;
      eo_q       <= 2'b00;
      weo_q      <= 1'b0;
      ei_q       <= 2'b00;
      winctl_q   <= 3'b000;
      en_eff_q   <= 1'b0;
      cen_eff_q  <= 2'b00;
      win_eff_q  <= 3'b000;
      sync_cnt_q <= 8'd0;
      busy_q     <= 1'b0;
      cctl_q[0]  <= acd_pkg::RST_VAL;
      cctl_q[1]  <= acd_pkg::RST_VAL;
    end
    else
    begin
      if (sync_wr)
      begin
        busy_q     <= 1'b1;
        sync_cnt_q <= 8'(SYNCD);
        pend_q     <= avs_writedata;
        pidx_q     <= avs_address;
      end
      else if (busy_q)
      begin
        sync_cnt_q <= sync_cnt_q - 8'd1;
        if (sync_cnt_q == 8'd1)
        begin
          busy_q <= 1'b0;
          case (pidx_q)
            acd_pkg::IX_CTRLA:  en_eff_q <= pend_q[acd_pkg::B_ENABLE];
            acd_pkg::IX_WINCTL: win_eff_q <= pend_q[2:0];
            acd_pkg::IX_CCTL0:  cen_eff_q[0] <= pend_q[acd_pkg::C_EN];
            acd_pkg::IX_CCTL1:  cen_eff_q[1] <= pend_q[acd_pkg::C_EN];
            default:            busy_q <= 1'b0;
          endcase
        end
      end
      if (wr && avs_address == acd_pkg::IX_CTRLA)
        ctrla_q <= wr_soft_reset_bit ? (ctrla_q | 3'b001) : avs_writedata[2:0];
      if (wr && avs_address == acd_pkg::IX_EVCTRL)
      begin
        eo_q  <= avs_writedata[1:0];
        weo_q <= avs_writedata[acd_pkg::B_WIN];
        ei_q  <= avs_writedata[acd_pkg::B_EI0 +: 2];
      end
      if (wr && avs_address == acd_pkg::IX_WINCTL)
        winctl_q <= avs_writedata[2:0];
      if (wr && is_cctl)
        cctl_q[cix] <= avs_writedata & acd_pkg::CCTL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // read path, one wait state
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  always_comb
  begin
    case (avs_address)
      acd_pkg::IX_CTRLA:  rmux = {29'd0, ctrla_q};
      acd_pkg::IX_EVCTRL: rmux = {22'd0, ei_q, 3'd0, weo_q, 2'd0, eo_q};
      acd_pkg::IX_IENCLR: rmux = {27'd0, ien_q[2], 2'd0, ien_q[1:0]};
      acd_pkg::IX_IENSET: rmux = {27'd0, ien_q[2], 2'd0, ien_q[1:0]};
      acd_pkg::IX_IFLAG:  rmux = {27'd0, flag_q[2], 2'd0, flag_q[1:0]};
      acd_pkg::IX_STATA:  rmux = {26'd0, ws_o, 2'd0, state_q};
      acd_pkg::IX_STATC:  rmux = {26'd0, ws_o, 2'd0, state_q};
      acd_pkg::IX_STATB:  rmux = {24'd0, busy_q, 5'd0, ready};
      acd_pkg::IX_WINCTL: rmux = {29'd0, winctl_q};
      acd_pkg::IX_CCTL0:  rmux = cctl_q[0];
      acd_pkg::IX_CCTL1:  rmux = cctl_q[1];
      default:            rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_done_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      rd_done_q <= avs_read && !rd_done_q;
      if (avs_read && !rd_done_q)
        rdata_q <= rmux;
    end
  end
endmodule : acd_ctrl

// ---- verification/acd_props.sv ----
// Purpose: port assertions for the comparator pair control block
// Assumes: one clock domain, asynchronous high reset
// Notes:   sees only the top module ports
module acd_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        standby,
  input wire logic [1:0]  comp_event_out,
  input wire logic        window_event_out,
  input wire logic        irq,
  input wire logic        wake_request
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic sync_ix;
  logic clr_all;
  assign sync_ix = avs_address inside {acd_pkg::IX_CTRLA, acd_pkg::IX_WINCTL,
                                       acd_pkg::IX_CCTL0, acd_pkg::IX_CCTL1};
  assign clr_all = avs_write && !avs_waitrequest
                   && avs_address == acd_pkg::IX_IENCLR
                   && avs_writedata[4:0] == 5'h13;
  logic run_sh;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      run_sh <= 1'b0;
    else if (avs_write && !avs_waitrequest &&
             avs_address == acd_pkg::IX_CTRLA)
      run_sh <= avs_writedata[acd_pkg::B_RUN] &&
                !avs_writedata[acd_pkg::B_SOFT_RESET_BIT];
  end
  a_plain_no_wait: assert property (avs_write && !sync_ix |-> !avs_waitrequest)
    else $error("unsynced write stalled");
  a_stall_bounded: assert property (avs_write |-> ##[0:4] !avs_waitrequest)
    else $error("write stall too long");
  a_read_one_wait: assert property (avs_read && !$past(avs_read) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait not one cycle");
  a_enclr_drops_irq: assert property (clr_all |=> !irq)
    else $error("irq kept after enable clear");
  a_wake_cause: assert property (wake_request |-> irq && standby)
    else $error("wake without enabled source in standby");
  a_wake_follows_irq: assert property (irq && standby && run_sh |-> wake_request)
    else $error("no wake for enabled source in standby");
  a_ev0_one_cycle: assert property (comp_event_out[0] |=> !comp_event_out[0])
    else $error("event 0 longer than one cycle");
  a_ev1_one_cycle: assert property (comp_event_out[1] |=> !comp_event_out[1])
    else $error("event 1 longer than one cycle");
  a_win_one_cycle: assert property (window_event_out |=> !window_event_out)
    else $error("window event longer than one cycle");
  c_stall: cover property (avs_write && avs_waitrequest);
  c_irq: cover property (irq);
  c_ev1: cover property (comp_event_out[1]);
endmodule : acd_chk
bind acd_ctrl acd_chk u_acd_chk (.clock(clock), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .standby(standby), .comp_event_out(comp_event_out),
  .window_event_out(window_event_out), .irq(irq),
  .wake_request(wake_request));

// ---- verification/acd_far_model.sv ----
// Purpose: analog comparator and event network stand-in
// Assumes: level 1 means positive input above negative input
// Notes:   swapped terminals invert the raw result
module acd_far_model (
  input  wire logic       clock,
  input  wire logic [1:0] level,
  input  wire logic [1:0] swap,
  input  wire logic [1:0] fire,
  output logic      [1:0] comp_result,
  output logic      [1:0] event_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // comparator and event source
  // ----------------------------------------------------------------
  assign comp_result = level ^ swap;
  always_ff @(posedge clock)
    event_in <= fire;
endmodule : acd_far_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the comparator pair control block
// Assumes: small start-up and divider parameters
// Notes:   expected values are written inline in the main sequence below
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals, model and tasks
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic        standby = 1'b0;
  logic        cpu_idle = 1'b0;
  logic [1:0]  level = '0;
  logic [1:0]  fire = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  comp_result, event_in, pin, power_en, swap, ev_out;
  logic        win_ev, irq, wake_request;
  logic [31:0] rdat, cc;
  int          fails = 0, compares = 0, stalls = 0;
  int          ev0_cnt = 0, ev1_cnt = 0, exp_ev0 = 0, win_cnt = 0;
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    ev0_cnt <= ev0_cnt + int'(ev_out[0]);
    ev1_cnt <= ev1_cnt + int'(ev_out[1]);
    win_cnt <= win_cnt + int'(win_ev);
  end
  acd_ctrl #(.STARTUP(4), .SYNCD(3), .SDIV(1)) u_acd_ctrl (
    .clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comp_result(comp_result),
    .event_in(event_in), .standby(standby), .cpu_idle(cpu_idle),
    .comparator_output_pin(pin), .comp_power_en(power_en),
    .comp_swap(swap), .comp_event_out(ev_out),
    .window_event_out(win_ev), .irq(irq), .wake_request(wake_request));
  acd_far_model u_acd_far_model (.clock(clock), .level(level),
    .swap(swap), .fire(fire), .comp_result(comp_result),
    .event_in(event_in));
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic err(input string m);
    fails++;
    $display("ERROR %0t %s", $time, m);
  endtask : err
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
      err("register or count mismatch");
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
      err("port level mismatch");
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clock);
    end
    rdat = avs_readdata;
    stalls = n;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
    begin
      err("bus wait ran out");
      print_verdict();
    end
  endtask : bus
  task automatic pulse(input int i);
    fire[i] <= 1'b1;
    @(posedge clock);
    fire[i] <= 1'b0;
  endtask : pulse
  task automatic wait_ev1(input int e);
    int n;
    n = 0;
    while (ev1_cnt < e && n < 80)
    begin
      n++;
      @(posedge clock);
    end
    if (n >= 80)
    begin
      err("event wait ran out");
      print_verdict();
    end
  endtask : wait_ev1
  initial
  begin
    #2_000_000;
    err("run timed out");
    print_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hfea0_8d01));
    cyc(10);
    rst <= 1'b0;
    bus(0, acd_pkg::IX_IFLAG, '0);
    chk_reg(rdat, acd_pkg::RST_VAL);
    bus(1, 5'h1F, $urandom());
    bus(0, 5'h1F, '0);
    chk_reg(rdat, 32'h0000_0000);
    cc = 32'h0001_0021;
    bus(1, acd_pkg::IX_CTRLA, 32'h0000_0002);
    bus(1, acd_pkg::IX_CCTL0, cc);
    chk_bit(stalls > 0, 1'b1);
    bus(0, acd_pkg::IX_STATB, '0);
    chk_bit(rdat[acd_pkg::B_BUSY], 1'b1);
    cyc(6);
    bus(0, acd_pkg::IX_STATB, '0);
    chk_bit(rdat[acd_pkg::B_BUSY], 1'b0);
    bus(0, acd_pkg::IX_CCTL0, '0);
    chk_reg(rdat, cc & acd_pkg::CCTL_MASK);
    bus(1, acd_pkg::IX_EVCTRL, 32'h0000_0001);
    bus(1, acd_pkg::IX_IENSET, 32'h0000_0001);
    for (int k = 0; k < 3; k++)
    begin
      bus(1, acd_pkg::IX_CCTL0, 32'h0001_0001 | (k << acd_pkg::C_COMP_IRQ_CONDITION_SELECT));
      cyc(8);
      bus(1, acd_pkg::IX_IFLAG, 32'h0000_0013);
      level[0] <= 1'b1;
      exp_ev0 += int'(k != 2);
      cyc(10);
      bus(0, acd_pkg::IX_IFLAG, '0);
      chk_bit(rdat[0], k != 2);
      chk_bit(irq, k != 2);
      chk_bit(pin[0], 1'b1);
      bus(1, acd_pkg::IX_IFLAG, 32'h0000_0001);
      cyc(1);
      chk_bit(irq, 1'b0);
      level[0] <= 1'b0;
      exp_ev0 += int'(k != 1);
      cyc(10);
      bus(0, acd_pkg::IX_IFLAG, '0);
      chk_bit(rdat[0], k != 1);
      bus(1, acd_pkg::IX_IFLAG, 32'h0000_0001);
    end
    bus(1, acd_pkg::IX_CCTL0, 32'h0001_0001);
    bus(1, acd_pkg::IX_CTRLA, 32'h0000_0006);
    level[0] <= 1'b1;
    exp_ev0++;
    cyc(10);
    standby <= 1'b1;
    cyc(2);
    chk_bit(wake_request, 1'b1);
    standby <= 1'b0;
    bus(1, acd_pkg::IX_IENCLR, 32'h0000_0013);
    cyc(1);
    chk_bit(irq, 1'b0);
    bus(1, acd_pkg::IX_CTRLA, 32'h0000_0002);
    cyc(5);
    standby <= 1'b1;
    cyc(3);
    chk_bit(power_en[0], 1'b0);
    standby <= 1'b0;
    bus(1, acd_pkg::IX_EVCTRL, 32'h0000_0000);
    bus(1, acd_pkg::IX_CCTL0, 32'h0000_0000);
    cyc(5);
    bus(1, acd_pkg::IX_CCTL0, 32'h0001_8000);
    cyc(5);
    chk_bit(swap[0], 1'b1);
    bus(1, acd_pkg::IX_CCTL0, 32'h0001_8001);
    cyc(6);
    chk_bit(pin[0], 1'b1);
    level[0] <= 1'b0;
    cyc(10);
    chk_reg(ev0_cnt, exp_ev0);
    bus(1, acd_pkg::IX_EVCTRL, 32'h0000_0002);
    bus(1, acd_pkg::IX_CCTL1, 32'h0002_0003);
    cyc(8);
    level[1] <= 1'b1;
    pulse(1);
    cyc(40);
    chk_reg(ev1_cnt, 0);
    bus(1, acd_pkg::IX_EVCTRL, 32'h0000_0202);
    pulse(1);
    wait_ev1(1);
    chk_reg(ev1_cnt, 1);
    bus(0, acd_pkg::IX_STATA, '0);
    chk_bit(rdat[1], 1'b1);
    chk_bit(pin[1], 1'b1);
    level[1] <= 1'b0;
    bus(1, acd_pkg::IX_CTRLB, 32'h0000_0002);
    bus(0, acd_pkg::IX_CTRLB, '0);
    chk_reg(rdat, 32'h0000_0000);
    wait_ev1(2);
    chk_reg(ev1_cnt, 2);
    bus(1, acd_pkg::IX_EVCTRL, 32'h0000_0010);
    bus(1, acd_pkg::IX_WINCTL, 32'h0000_0003);
    cyc(5);
    level[0] <= 1'b1;
    cyc(10);
    bus(0, acd_pkg::IX_IFLAG, '0);
    chk_bit(rdat[acd_pkg::B_WIN], 1'b1);
    chk_reg(win_cnt, 1);
    bus(1, acd_pkg::IX_CTRLA, 32'h0000_0001);
    cyc(6);
    bus(0, acd_pkg::IX_CCTL1, '0);
    chk_reg(rdat, 32'h0000_0000);
    print_verdict();
  end
endmodule : tb_top
